// ### common/ivp_pkg.sv
// Constants for the maskable interrupt vector and priority map.
// Assumes a single system clock; the arbiter shares only the source
// count and width values here with the controller.
package ivp_pkg;

  // Source count and programmable level width.
  localparam int IVP_NUM_SRC = 42;
  localparam int IVP_LVL_W = 3;
  localparam int IVP_IDX_W = 6;
  localparam int IVP_NUM_LVL = 8;

  // Status word bit positions.
  localparam int IVP_PSW_NP = 7;
  localparam int IVP_PSW_EP = 6;
  localparam int IVP_PSW_ID = 5;
  localparam logic [31:0] IVP_PSW_RESET = 32'h0000_0020;

  // Fixed exception codes of the non-maskable and illegal-opcode paths.
  localparam logic [15:0] IVP_NMI_CODE = 16'h0010;
  localparam logic [15:0] IVP_ILGOP_CODE = 16'h0060;

  // Offset between a faulting instruction and the value saved for it.
  localparam logic [31:0] IVP_ILGOP_OFFSET = 32'h0000_0004;

  // Group bases of the used vector slots, in default-priority order.
  localparam logic [15:0] IVP_BASE_PIN = 16'h0080;
  localparam logic [15:0] IVP_BASE_TMQ = 16'h0120;
  localparam logic [15:0] IVP_BASE_TMP = 16'h0240;
  localparam logic [15:0] IVP_BASE_SER = 16'h0340;
  localparam logic [15:0] IVP_CODE_CONV0 = 16'h0400;
  localparam logic [15:0] IVP_CODE_CONV1 = 16'h0410;
  localparam logic [15:0] IVP_CODE_CMP0 = 16'h0430;
  localparam logic [15:0] IVP_SLOT_STEP = 16'h0010;

  // First default priority of each group, plus the priority of clocked serial done.
  localparam int IVP_FIRST_TMQ = 8;
  localparam int IVP_FIRST_TMP = 18;
  localparam int IVP_FIRST_SER = 30;
  localparam int IVP_PRI_CONV0 = 39;
  localparam int IVP_PRI_CONV1 = 40;
  localparam int IVP_PRI_CMP0 = 41;
  localparam int IVP_PRI_CSER_DONE = 34;

  // Exception code of a source by default priority; unused slots between
  // groups are skipped, so no reserved slot can ever be produced.
  function automatic logic [15:0] ivp_code_of(input int unsigned idx);
    logic [15:0] off;
    off = 16'h0000;
    if (idx < IVP_FIRST_TMQ) begin
      off = 16'(idx);
      ivp_code_of = IVP_BASE_PIN + off * IVP_SLOT_STEP;
    end else if (idx < IVP_FIRST_TMP) begin
      off = 16'(idx - IVP_FIRST_TMQ);
      ivp_code_of = IVP_BASE_TMQ + off * IVP_SLOT_STEP;
    end else if (idx < IVP_FIRST_SER) begin
      off = 16'(idx - IVP_FIRST_TMP);
      ivp_code_of = IVP_BASE_TMP + off * IVP_SLOT_STEP;
    end else if (idx < IVP_PRI_CONV0) begin
      off = 16'(idx - IVP_FIRST_SER);
      ivp_code_of = IVP_BASE_SER + off * IVP_SLOT_STEP;
    end else if (idx == IVP_PRI_CONV0) begin
      ivp_code_of = IVP_CODE_CONV0;
    end else if (idx == IVP_PRI_CONV1) begin
      ivp_code_of = IVP_CODE_CONV1;
    end else begin
      ivp_code_of = IVP_CODE_CMP0;
    end
  endfunction : ivp_code_of

endpackage : ivp_pkg

// ### dv/ivp_controller_assertions.sv
// Port-level checks of maskable vectoring and return-state saving.
// Assumes it is bound into each controller instance.
`timescale 1ns/1ps
module ivp_controller_assertions
  import ivp_pkg::*;
#(
  parameter int N = IVP_NUM_SRC,
  parameter int LW = IVP_LVL_W,
  parameter int IW = IVP_IDX_W
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic illegal_opcode,
  input wire logic [N-1:0] source_mask,
  input wire logic [31:0] core_pc,
  input wire logic [31:0] following_instruction_address,
  input wire logic abortable_in_progress,
  input wire logic vector_valid,
  input wire logic [31:0] handler_address,
  input wire logic [IW-1:0] granted_index,
  input wire logic [31:0] maskable_return_pc,
  input wire logic [31:0] maskable_saved_status,
  input wire logic [15:0] maskable_cause_halfword,
  input wire logic [31:0] debug_return_pc,
  input wire logic [31:0] status_word,
  input wire logic [N-1:0] pending_flags
);
  wire logic mv;
  // A maskable vector is any vector not on the two fixed paths.
  assign mv = vector_valid && handler_address != 32'h10
    && handler_address != 32'h60;
  logic [31:0] ilg_pc_q;
  // address of the faulting instruction, kept from the pulse cycle.
  always_ff @(posedge clock) begin
    if (illegal_opcode) begin
      ilg_pc_q <= core_pc;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  sequence s_take;
    mv;
  endsequence
  property p_hnd;
    s_take |-> handler_address == {16'h0, maskable_cause_halfword}
      && maskable_cause_halfword[3:0] == 4'h0 && granted_index < N;
  endproperty
  a_hnd: assert property (p_hnd) else $error("bad handler");
  property p_ret;
    s_take |-> maskable_return_pc == ($past(abortable_in_progress) ?
      $past(core_pc) : $past(following_instruction_address));
  endproperty
  a_ret: assert property (p_ret) else $error("bad return");
  property p_ilg;
    vector_valid && handler_address == 32'h60 |->
      debug_return_pc - 32'h4 == ilg_pc_q;
  endproperty
  a_ilg: assert property (p_ilg) else $error("bad debug pc");
  property p_saved;
    s_take |-> maskable_saved_status == $past(status_word);
  endproperty
  a_saved: assert property (p_saved) else $error("bad saved");
  property p_st;
    s_take |-> status_word[IVP_PSW_ID] && !status_word[IVP_PSW_EP];
  endproperty
  a_st: assert property (p_st) else $error("bad status");
  property p_msk;
    s_take |-> !(($past(source_mask) >> granted_index) & 1);
  endproperty
  a_msk: assert property (p_msk) else $error("masked grant");
  property p_clr;
    s_take |-> !pending_flags[granted_index];
  endproperty
  a_clr: assert property (p_clr) else $error("still pending");
  property p_blk;
    status_word[IVP_PSW_ID] |=> !mv;
  endproperty
  a_blk: assert property (p_blk) else $error("grant while off");
endmodule : ivp_controller_assertions

bind ivp_controller ivp_controller_assertions #(.N(N), .LW(LW), .IW(IW))
  ivp_chk_i (.clock(clock), .rst_n(rst_n), .source_mask(source_mask),
  .core_pc(core_pc), .vector_valid(vector_valid),
  .illegal_opcode(illegal_opcode),
  .following_instruction_address(following_instruction_address),
  .abortable_in_progress(abortable_in_progress),
  .handler_address(handler_address), .granted_index(granted_index),
  .maskable_return_pc(maskable_return_pc),
  .maskable_saved_status(maskable_saved_status),
  .maskable_cause_halfword(maskable_cause_halfword),
  .debug_return_pc(debug_return_pc), .status_word(status_word),
  .pending_flags(pending_flags));

// ### dv/ivp_core_model.sv
// Core stand-in that reloads status after each vector it is handed.
// Assumes the controller's one-cycle vector pulse on the shared clock.
`timescale 1ns/1ps
module ivp_core_model (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic vector_valid,
  output logic status_load,
  output logic [31:0] status_wdata,
  output logic return_done
);
  bit started;
  // re-enable grants.
  // A random pause models both prompt and slow handlers; no return is
  // issued before the first vector, as a real core would not.
  initial begin
    status_load = 1'b0;
    status_wdata = 32'h0;
    return_done = 1'b0;
    @(posedge rst_n);
    forever begin
      repeat ($urandom_range(3) + 1) @(posedge clock);
      status_load <= 1'b1;
      status_wdata <= 32'h0;
      return_done <= started;
      @(posedge clock);
      status_load <= 1'b0;
      return_done <= 1'b0;
      status_wdata <= $urandom;
      started = 1'b1;
      while (!vector_valid) @(posedge clock);
    end
  end
endmodule : ivp_core_model

// ### dv/tb_top.sv
// Self-checking bench: a queue-free pending model predicts each grant.
// Assumes the core stand-in reloads status after every vector.
`timescale 1ns/1ps
`define CHK(nm, e, s) begin \
  n_tests++; \
  if ((s) !== (e)) begin \
    fail_count++; \
    $display("mismatch %s exp %h got %h", nm, e, s); \
  end \
end
module tb_top;
  import ivp_pkg::*;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [41:0] source_request = '0;
  logic [41:0] source_mask = '0;
  logic [125:0] source_level = '0;
  logic nmi_request = 1'b0;
  logic illegal_opcode = 1'b0;
  logic [31:0] core_pc = '0;
  logic [31:0] following_instruction_address = '0;
  logic abortable_in_progress = 1'b0;
  logic status_load, return_done, vector_valid;
  logic [31:0] status_wdata, handler_address, maskable_return_pc;
  logic [31:0] maskable_saved_status, nonmaskable_return_pc;
  logic [31:0] debug_return_pc, status_word;
  logic [5:0] granted_index;
  logic [15:0] maskable_cause_halfword;
  logic [41:0] pending_flags;
  logic [41:0] pend = '0;
  int fail_count = 0;
  int n_tests = 0;
  int cyc = 0;
  ivp_controller ivp_controller_i (.clock(clock), .rst_n(rst_n),
    .source_request(source_request), .source_mask(source_mask),
    .source_level(source_level), .nmi_request(nmi_request),
    .illegal_opcode(illegal_opcode), .core_pc(core_pc),
    .following_instruction_address(following_instruction_address),
    .abortable_in_progress(abortable_in_progress),
    .status_load(status_load), .status_wdata(status_wdata),
    .return_done(return_done), .vector_valid(vector_valid),
    .handler_address(handler_address), .granted_index(granted_index),
    .maskable_return_pc(maskable_return_pc),
    .maskable_saved_status(maskable_saved_status),
    .maskable_cause_halfword(maskable_cause_halfword),
    .nonmaskable_return_pc(nonmaskable_return_pc),
    .debug_return_pc(debug_return_pc), .status_word(status_word),
    .pending_flags(pending_flags));
  ivp_core_model ivp_core_model_i (.clock(clock), .rst_n(rst_n),
    .vector_valid(vector_valid), .status_load(status_load),
    .status_wdata(status_wdata), .return_done(return_done));
  // Free-running system clock.
  always #2.5 clock = ~clock;
  // A hang counts as a mismatch and ends the run.
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      end_sim();
    end
  end
  function automatic logic [15:0] code_of(input int i);
    if (i < 8) return 16'h0080 + 16'(i * 16);
    if (i < 18) return 16'h0120 + 16'((i - 8) * 16);
    if (i < 30) return 16'h0240 + 16'((i - 18) * 16);
    if (i < 39) return 16'h0340 + 16'((i - 30) * 16);
    return (i == 39) ? 16'h0400 : (i == 40) ? 16'h0410 : 16'h0430;
  endfunction : code_of
  // level then order; strict compare keeps the lower number.
  function automatic int winner();
    int w;
    w = -1;
    for (int i = 0; i < 42; i++) begin
      if (pend[i] && !source_mask[i] && (w < 0 ||
          source_level[i*3+:3] < source_level[w*3+:3])) w = i;
    end
    return w;
  endfunction : winner
  task automatic wait_vec();
    int k;
    k = 0;
    do begin
      @(posedge clock);
      #1;
      k++;
    end while (vector_valid !== 1'b1 && k < 60);
    `CHK("vector", 1'b1, vector_valid)
  endtask : wait_vec
  task automatic fire(input logic [41:0] b, input logic [41:0] m,
                      input logic [125:0] lv);
    logic [31:0] pc;
    pc = $urandom;
    @(posedge clock);
    source_request <= b;
    source_mask <= m;
    source_level <= lv;
    core_pc <= pc;
    following_instruction_address <= pc + 32'h4;
    abortable_in_progress <= pc[0];
    pend = pend | b;
    @(posedge clock);
    source_request <= '0;
    #1;
  endtask : fire
  task automatic drain();
    int w;
    logic [31:0] rp;
    w = winner();
    while (w >= 0) begin
      wait_vec();
      rp = abortable_in_progress ? core_pc : following_instruction_address;
      `CHK("index", 6'(w), granted_index)
      `CHK("hnd", {16'h0, code_of(w)}, handler_address)
      `CHK("cause", code_of(w), maskable_cause_halfword)
      `CHK("ret", rp, maskable_return_pc)
      `CHK("status", 3'b001, status_word[7:5])
      pend[w] = 1'b0;
      w = winner();
    end
    `CHK("pending", pend, pending_flags)
  endtask : drain
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_sim
  // Main sequence: singles, random bursts, then alternating non-maskable and illegal events.
  initial begin
    logic [125:0] lv;
    logic [31:0] pc;
    void'($urandom(88630));
    repeat (20) @(posedge clock);
    #1;
    `CHK("reset", 32'h20, status_word)
    @(posedge clock);
    rst_n <= 1'b1;
    for (int i = 0; i < 42; i++) begin
      fire(42'h1 << i, '0, '0);
      drain();
    end
    $display("test singles done");
    for (int t = 0; t < 24; t++) begin
      lv = 126'({$urandom, $urandom, $urandom, $urandom});
      fire(42'({$urandom, $urandom} & {$urandom, $urandom}),
           42'({$urandom, $urandom}), t[0] ? lv : '0);
      drain();
      @(posedge clock);
      source_mask <= '0;
      #1;
      drain();
    end
    $display("test bursts done");
    // Non-maskable and illegal events alternate; the core moves on right
    // after an illegal pulse, so the saved address must come from it.
    for (int t = 0; t < 8; t++) begin
      pc = $urandom;
      @(posedge clock);
      illegal_opcode <= !t[0];
      nmi_request <= t[0];
      core_pc <= pc;
      following_instruction_address <= pc + 32'h4;
      abortable_in_progress <= pc[1];
      @(posedge clock);
      illegal_opcode <= 1'b0;
      nmi_request <= 1'b0;
      if (!t[0]) begin
        core_pc <= ~pc;
      end
      wait_vec();
      if (t[0]) begin
        `CHK("nmi hnd", 32'h10, handler_address)
        `CHK("nmi pc", pc[1] ? pc : pc + 32'h4, nonmaskable_return_pc)
        `CHK("nmi status", 3'b101, status_word[7:5])
      end else begin
        `CHK("ilg hnd", 32'h60, handler_address)
        `CHK("ilg pc", pc, debug_return_pc - 32'h4)
        `CHK("ilg status", 3'b011, status_word[7:5])
      end
    end
    $display("test illegal done");
    end_sim();
  end
endmodule : tb_top

// ### src/ivp_arbiter.sv
// Picks the winning pending request: lowest programmed level first,
// lowest default priority number among equal levels.
// Assumes request and level inputs are on the caller's clock.
`timescale 1ns/1ps
module ivp_arbiter
  import ivp_pkg::*;
#(
  parameter int N = IVP_NUM_SRC,
  parameter int LW = IVP_LVL_W,
  parameter int IW = IVP_IDX_W
) (
  input wire logic [N-1:0] request,
  input wire logic [N*LW-1:0] level,
  output logic found,
  output logic [IW-1:0] index,
  output logic [LW-1:0] win_level
);

  // Walk from the highest number down; a later hit at an equal or lower
  // level overwrites, so ties resolve toward number 0.
  always_comb begin
    found = 1'b0;
    index = '0;
    win_level = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (request[i] && (!found || level[i*LW +: LW] <= win_level)) begin
        found = 1'b1;
        index = IW'(i);
        win_level = level[i*LW +: LW];
      end
    end
  end

endmodule : ivp_arbiter

// ### src/ivp_controller.sv
// Maskable interrupt vectoring and return-state saving for the core.
// Assumes every request input is a one-cycle pulse from logic on clock,
// and that the core reports its current and following addresses.
//
// Functional notes
// - First converter done gets priority 39, code 0400h, handler 400h.
// - Second converter done gets priority 40, code 0410h, handler 410h.
// - Compare timer match gets lowest priority 41, code 0430h.
// - Clocked serial done gets priority 34, code 0380h, handler 380h.
// - Simultaneous requests at equal levels are granted in default order, 0 first.
// - Servicing saves the return address, normally the next one.
// - An abortable instruction in flight saves its own address.
// - Illegal opcode saves a value four above the faulting address.
// - Maskable acceptance saves pc and status, writes cause, sets ID, clears EP.
// - Masked or blocked requests stay pending until they can be served.
// - Eight programmable levels rank first; default order breaks ties.
`timescale 1ns/1ps
module ivp_controller
  import ivp_pkg::*;
#(
  parameter int N = IVP_NUM_SRC,
  parameter int LW = IVP_LVL_W,
  parameter int IW = IVP_IDX_W
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [N-1:0] source_request,
  input wire logic [N-1:0] source_mask,
  input wire logic [N*LW-1:0] source_level,
  input wire logic nmi_request,
  input wire logic illegal_opcode,
  input wire logic [31:0] core_pc,
  input wire logic [31:0] following_instruction_address,
  input wire logic abortable_in_progress,
  input wire logic status_load,
  input wire logic [31:0] status_wdata,
  input wire logic return_done,
  output logic vector_valid,
  output logic [31:0] handler_address,
  output logic [IW-1:0] granted_index,
  output logic [31:0] maskable_return_pc,
  output logic [31:0] maskable_saved_status,
  output logic [15:0] maskable_cause_halfword,
  output logic [31:0] nonmaskable_return_pc,
  output logic [31:0] debug_return_pc,
  output logic [31:0] status_word,
  output logic [N-1:0] pending_flags
);

  // The code table and index width are fixed to the documented map.
  if (N != IVP_NUM_SRC || LW != IVP_LVL_W || IW != IVP_IDX_W) begin : g_chk
    $error("ivp_controller: parameters do not match the vector map");
  end

  typedef enum logic [1:0] {
    IVP_TAKE_NONE = 2'b00,
    IVP_TAKE_NMI = 2'b01,
    IVP_TAKE_ILG = 2'b10,
    IVP_TAKE_MSK = 2'b11
  } ivp_take_t;

  logic [N-1:0] pend_q;
  logic nmi_pend_q;
  logic ilg_pend_q;
  logic [31:0] ilg_pc_q;
  logic [31:0] status_q;
  logic svc_active_q;
  logic [LW-1:0] svc_level_q;
  logic valid_q;
  logic [31:0] handler_q;
  logic [IW-1:0] grant_q;
  logic [31:0] mret_q;
  logic [31:0] mstat_q;
  logic [15:0] mcause_q;
  logic [31:0] nret_q;
  logic [31:0] dret_q;
  logic arb_found;
  logic [IW-1:0] arb_index;
  logic [LW-1:0] arb_level;
  logic level_ok;
  logic [N-1:0] clr_mask;
  logic [31:0] ret_pc;
  logic [15:0] win_code;
  ivp_take_t take;

  ivp_arbiter #(
    .N(N),
    .LW(LW),
    .IW(IW)
  ) u_arb (
    .request(pend_q & ~source_mask),
    .level(source_level),
    .found(arb_found),
    .index(arb_index),
    .win_level(arb_level)
  );

  always_comb begin
    win_code = ivp_code_of(int'(arb_index));
  end

  // level nesting
  // Only one in-service level is tracked: after a nested return the outer
  // level is forgotten, so software must restore ID before re-enabling.
  assign level_ok = !svc_active_q || (arb_level < svc_level_q);

  // acceptance order
  // A status load from the core in the same cycle defers acceptance, so
  // the core's write is never overwritten by a stale status.
  always_comb begin
    take = IVP_TAKE_NONE;
    if (!status_load && !status_q[IVP_PSW_NP]) begin
      if (nmi_pend_q) begin
        take = IVP_TAKE_NMI;
      end else if (ilg_pend_q) begin
        take = IVP_TAKE_ILG;
      end else if (arb_found && !status_q[IVP_PSW_ID] && level_ok) begin
        take = IVP_TAKE_MSK;
      end
    end
  end

  assign ret_pc = abortable_in_progress ? core_pc
                                        : following_instruction_address;

  always_comb begin
    clr_mask = '0;
    if (take == IVP_TAKE_MSK) begin
      clr_mask[arb_index] = 1'b1;
    end
  end

  // pending flags
  // A new request in the grant cycle sets the flag again: set wins.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pend_q <= '0;
    end else begin
      pend_q <= (pend_q & ~clr_mask) | source_request;
    end
  end

  // Non-maskable and illegal-opcode events are held until served.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      nmi_pend_q <= 1'b0;
      ilg_pend_q <= 1'b0;
    end else begin
      nmi_pend_q <= (nmi_pend_q && take != IVP_TAKE_NMI) || nmi_request;
      ilg_pend_q <= (ilg_pend_q && take != IVP_TAKE_ILG) || illegal_opcode;
    end
  end

  // faulting address capture
  // The core may move on before the exception is taken, so the address
  // is kept from the cycle of the pulse itself.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ilg_pc_q <= 32'h0000_0000;
    end else if (illegal_opcode) begin
      ilg_pc_q <= core_pc;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      status_q <= IVP_PSW_RESET;
    end else if (status_load) begin
      status_q <= status_wdata;
    end else if (take == IVP_TAKE_NMI) begin
      status_q[IVP_PSW_NP] <= 1'b1;
      status_q[IVP_PSW_ID] <= 1'b1;
      status_q[IVP_PSW_EP] <= 1'b0;
    end else if (take == IVP_TAKE_ILG) begin
      status_q[IVP_PSW_ID] <= 1'b1;
      status_q[IVP_PSW_EP] <= 1'b1;
    end else if (take == IVP_TAKE_MSK) begin
      status_q[IVP_PSW_ID] <= 1'b1;
      status_q[IVP_PSW_EP] <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      svc_active_q <= 1'b0;
      svc_level_q <= '0;
    end else if (take == IVP_TAKE_MSK) begin
      svc_active_q <= 1'b1;
      svc_level_q <= arb_level;
    end else if (return_done) begin
      svc_active_q <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mret_q <= 32'h0000_0000;
      mstat_q <= 32'h0000_0000;
      mcause_q <= 16'h0000;
    end else if (take == IVP_TAKE_MSK) begin
      mret_q <= ret_pc;
      mstat_q <= status_q;
      mcause_q <= win_code;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      nret_q <= 32'h0000_0000;
    end else if (take == IVP_TAKE_NMI) begin
      nret_q <= ret_pc;
    end
  end

  // illegal opcode save
  // The faulting address is the saved value minus four.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      dret_q <= 32'h0000_0000;
    end else if (take == IVP_TAKE_ILG) begin
      dret_q <= ilg_pc_q + IVP_ILGOP_OFFSET;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      valid_q <= 1'b0;
      handler_q <= 32'h0000_0000;
      grant_q <= '0;
    end else begin
      valid_q <= (take != IVP_TAKE_NONE);
      unique case (take)
        IVP_TAKE_NONE: begin
          handler_q <= handler_q;
        end
        IVP_TAKE_NMI: begin
          handler_q <= {16'h0000, IVP_NMI_CODE};
        end
        IVP_TAKE_ILG: begin
          handler_q <= {16'h0000, IVP_ILGOP_CODE};
        end
        IVP_TAKE_MSK: begin
          handler_q <= {16'h0000, win_code};
          grant_q <= arb_index;
        end
      endcase
    end
  end

  // Every output is a flip-flop.
  assign vector_valid = valid_q;
  assign handler_address = handler_q;
  assign granted_index = grant_q;
  assign maskable_return_pc = mret_q;
  assign maskable_saved_status = mstat_q;
  assign maskable_cause_halfword = mcause_q;
  assign nonmaskable_return_pc = nret_q;
  assign debug_return_pc = dret_q;
  assign status_word = status_q;
  assign pending_flags = pend_q;

endmodule : ivp_controller
